/* File: verilog/viu_regs.svh */
// register map, field positions and reset values of the vectored interrupt unit
// assumes 32-bit apb data, one aligned word per register, byte address = index * 4
`ifndef VIU_REGS_SVH
`define VIU_REGS_SVH

// register indices; the byte address is the index shifted left by two
`define VIU_IDX_SETUP      10'h007
`define VIU_IDX_FLAG_LOW   10'h011
`define VIU_IDX_FLAG_HIGH  10'h012
`define VIU_IDX_EN_LOW     10'h020
`define VIU_IDX_EN_HIGH    10'h021
`define VIU_IDX_IRQ_STAT   10'h022
`define VIU_IDX_IRQ_MASK   10'h023
`define VIU_IDX_CORE_STATE 10'h024

// field positions
`define VIU_SETUP_AUTO_BIT 5
`define VIU_EVT_ACCEPT     0
`define VIU_EVT_RETURN     1
`define VIU_EVT_MASKED     2

// reset values
`define VIU_SETUP_RST      8'h00
`define VIU_FLAG_RST       16'h0000
`define VIU_EN_RST         16'h0000
`define VIU_EVT_RST        3'h0

// call targets: sources 0..14 call 1..15, source 15 calls 17, 16 is never used
`define VIU_LAST_TARGET    5'h11
`define VIU_HOLE_TARGET    5'h10

`endif

/* File: verilog/viu_pkg.sv */
// types shared by the vectored interrupt unit
// assumes nothing beyond a systemverilog compiler
package viu_pkg;

    // sequencing of one interrupt entry and exit
    typedef enum logic [1:0] {
        VIU_IDLE,
        VIU_SERVICE,
        VIU_GUARD
    } viu_state_e;

endpackage : viu_pkg

/* File: verilog/viu_prio_pick.sv */
// fixed-order pick of the first enabled pending source and its call target
// assumes bit 0 is the most urgent source and bit 15 the least
`timescale 1ns/1ps
`default_nettype none
`include "viu_regs.svh"

module viu_prio_pick
    import viu_pkg::*;
(
    input  wire logic [15:0] pend,   // pending and enabled sources
    output logic             found,  // at least one source waits
    output logic [4:0]       target  // call target of the winner
);
    logic [16:0]   above;            // some more urgent source is pending
    logic [4:0]    code_acc [0:16];  // target accumulated down the chain

    assign above[0]    = 1'b0;
    assign code_acc[0] = 5'h00;

    // one stage per source: it wins only if nothing above it is pending
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_stage
            localparam logic [4:0] CODE = (i == 15) ? `VIU_LAST_TARGET : 5'(i + 1);
            logic hit;
            assign hit           = pend[i] & ~above[i];
            assign above[i+1]    = above[i] | pend[i];
            assign code_acc[i+1] = code_acc[i] | ({5{hit}} & CODE);
        end
    endgenerate

    assign found  = above[16];
    assign target = code_acc[16];

endmodule : viu_prio_pick
`default_nettype wire

/* File: verilog/viu_core.sv */
// vectored interrupt unit: flags, enables, fixed-order pick, call injection,
// nesting guard and optional accumulator/status save, behind an apb slave
// assumes the cpu sequencer and the event sources run on pclk
`timescale 1ns/1ps
`default_nettype none
`include "viu_regs.svh"

module viu_core
    import viu_pkg::*;
(
    input  wire logic        pclk,            // system clock, 40 mhz
    input  wire logic        presetn,         // asynchronous reset, active low
    input  wire logic        ce,              // clock enable, freezes all state when low
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb access phase
    input  wire logic        pwrite,          // apb direction
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // apb error for unmapped address
    input  wire logic [15:0] src_event,       // per-source event level, bit 0 most urgent
    input  wire logic        instr_done,      // current instruction completes this cycle
    input  wire logic        instr_is_reti,   // the completing instruction is a return
    input  wire logic [7:0]  acc_in,          // live accumulator
    input  wire logic [7:0]  status_in,       // live status register
    output logic             inject_call,     // insert a call instead of the next fetch
    output logic      [4:0]  call_target,     // address of the inserted call
    output logic             restore_ctx,     // load the saved context back
    output logic      [7:0]  acc_restore,     // saved accumulator
    output logic      [7:0]  status_restore,  // saved status
    output logic             wake_req,        // leave low-power state
    output logic      [4:0]  clk_setup,       // oscillator and divider bits of setup
    output logic             irq              // summary interrupt, level
);

    // a named copy of the reset image, because bits cannot be selected from a bare literal
    localparam logic [7:0] SETUP_RST = `VIU_SETUP_RST;

    viu_state_e    state;           // entry/exit sequencer
    logic [15:0]   flag;            // request flags, one per source
    logic [15:0]   en;              // individual enables
    logic          auto_save;       // context save enabled
    logic          in_service;      // high from entry until the guarded instruction ends, read back only
    logic [2:0]    evt_stat;        // sticky block events
    logic [2:0]    evt_mask;        // mask of the summary interrupt
    logic [15:0]   en_pend;         // enabled pending requests
    logic          pick_found;      // something to vector to
    logic [4:0]    pick_target;     // its call target
    logic          accept;          // take an interrupt at this edge
    logic          reti_done;       // the handler returns at this edge
    logic [2:0]    evt_now;         // events arising this cycle
    logic          apb_acc;         // access phase completes at this edge
    logic          wr_go;           // register write takes effect
    logic [9:0]    idx;             // register index from the address
    logic [15:0]   keep_low;        // keep mask from a low flag write
    logic [15:0]   keep_high;       // keep mask from a high flag write
    logic [7:0]    flag_low_view;   // flag register 11h as read
    logic [7:0]    flag_high_view;  // flag register 12h as read
    logic [31:0]   next_rdata;      // read mux
    logic          next_err;        // unmapped address

    // pick the winner among enabled requests
    assign en_pend = flag & en;
    viu_prio_pick u_pick (
        .pend   (en_pend),
        .found  (pick_found),
        .target (pick_target)
    );

    // entry is allowed at an instruction end, outside service; the guard
    // state is the instruction after the return, which may end in an entry
    assign accept    = ce && instr_done && pick_found && (state != VIU_SERVICE);
    assign reti_done = ce && instr_done && instr_is_reti && (state == VIU_SERVICE);

    // apb decode
    assign idx     = paddr[11:2];
    assign apb_acc = psel && penable && pready;
    assign wr_go   = ce && apb_acc && pwrite && !pslverr;

    // flag register bit layout: low byte holds sources 0..7 from bit 7 down,
    // high byte scatters sources 8..15 as the data map shows
    assign flag_low_view  = {flag[0], flag[1], flag[2], flag[3],
                             flag[4], flag[5], flag[6], flag[7]};
    assign flag_high_view = {flag[15], flag[14], flag[10], flag[8],
                             flag[9], flag[13], flag[12], flag[11]};

    // write zero to clear, one to keep; only a whole-byte write is safe
    // because a read-modify-write could turn a fresh set into a zero
    always_comb begin
        keep_low  = 16'hFFFF;
        keep_high = 16'hFFFF;
        if (wr_go && idx == `VIU_IDX_FLAG_LOW) begin
            keep_low[7:0] = {pwdata[0], pwdata[1], pwdata[2], pwdata[3],
                             pwdata[4], pwdata[5], pwdata[6], pwdata[7]};
        end
        if (wr_go && idx == `VIU_IDX_FLAG_HIGH) begin
            keep_high[15:8] = {pwdata[7], pwdata[6], pwdata[2], pwdata[1],
                               pwdata[0], pwdata[5], pwdata[3], pwdata[4]};
        end
    end

    // request flags: the event level sets and wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= `VIU_FLAG_RST;
        end else if (ce) begin
            flag <= (flag & keep_low & keep_high) | src_event;
        end
    end

    // individual enables, one bit per source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en <= `VIU_EN_RST;
        end else if (wr_go && idx == `VIU_IDX_EN_LOW) begin
            en[7:0] <= pwdata[7:0];
        end else if (wr_go && idx == `VIU_IDX_EN_HIGH) begin
            en[15:8] <= pwdata[7:0];
        end
    end

    // setup register is write-only; bit 5 steers the context save
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_save <= SETUP_RST[`VIU_SETUP_AUTO_BIT];
            clk_setup <= SETUP_RST[4:0];
        end else if (wr_go && idx == `VIU_IDX_SETUP) begin
            auto_save <= pwdata[`VIU_SETUP_AUTO_BIT];
            clk_setup <= pwdata[4:0];
        end
    end

    // sequencer: idle, in service, then one guarded instruction after return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= VIU_IDLE;
            in_service <= 1'b0;
        end else if (ce) begin
            case (state)
                VIU_IDLE: begin
                    if (accept) begin
                        state      <= VIU_SERVICE;
                        in_service <= 1'b1;
                    end
                end
                VIU_SERVICE: begin
                    if (reti_done) begin
                        state <= VIU_GUARD;
                    end
                end
                VIU_GUARD: begin
                    // in_service drops at the end of the instruction after the return unless an entry is taken
                    if (accept) begin
                        state <= VIU_SERVICE;
                    end else if (instr_done) begin
                        state      <= VIU_IDLE;
                        in_service <= 1'b0;
                    end
                end
                default: begin
                    state      <= VIU_IDLE;
                    in_service <= 1'b0;
                end
            endcase
        end
    end

    // call injection: one pulse with the winner's target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inject_call <= 1'b0;
            call_target <= 5'h00;
        end else if (ce) begin
            inject_call <= accept;
            if (accept) begin
                call_target <= pick_target;
            end
        end
    end

    // context save on entry and restore pulse on exit, both only when enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_restore    <= 8'h00;
            status_restore <= 8'h00;
            restore_ctx    <= 1'b0;
        end else if (ce) begin
            if (accept && auto_save) begin
                acc_restore    <= acc_in;
                status_restore <= status_in;
            end
            restore_ctx <= reti_done && auto_save;
        end
    end

    // wake request follows any enabled pending flag, even while in service
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_req <= 1'b0;
        end else if (ce) begin
            wake_req <= |en_pend;
        end
    end

    // block events: entry, return, and an event on a disabled source
    assign evt_now = {ce && |(src_event & ~en), reti_done, accept};

    // sticky event status, write one to clear, a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_stat <= `VIU_EVT_RST;
            evt_mask <= `VIU_EVT_RST;
        end else if (ce) begin
            if (wr_go && idx == `VIU_IDX_IRQ_STAT) begin
                evt_stat <= (evt_stat & ~pwdata[2:0]) | evt_now;
            end else begin
                evt_stat <= evt_stat | evt_now;
            end
            if (wr_go && idx == `VIU_IDX_IRQ_MASK) begin
                evt_mask <= pwdata[2:0];
            end
        end
    end

    // summary interrupt, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(evt_stat & evt_mask);
        end
    end

    // read mux and decode error; the setup register reads as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (idx)
            `VIU_IDX_SETUP:      next_rdata = 32'h0000_0000;
            `VIU_IDX_FLAG_LOW:   next_rdata = {24'h00_0000, flag_low_view};
            `VIU_IDX_FLAG_HIGH:  next_rdata = {24'h00_0000, flag_high_view};
            `VIU_IDX_EN_LOW:     next_rdata = {24'h00_0000, en[7:0]};
            `VIU_IDX_EN_HIGH:    next_rdata = {24'h00_0000, en[15:8]};
            `VIU_IDX_IRQ_STAT:   next_rdata = {29'h0000_0000, evt_stat};
            `VIU_IDX_IRQ_MASK:   next_rdata = {29'h0000_0000, evt_mask};
            `VIU_IDX_CORE_STATE: next_rdata = {16'h0000, acc_restore, auto_save,
                                               in_service, 1'b0, call_target};
            default:             next_err   = 1'b1;
        endcase
    end

    // apb slave: one wait state, ready and data registered together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                pslverr <= next_err;
                prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // helpers for the checks below
    logic [3:0] tgt_idx;            // source index of the current target
    assign tgt_idx = (call_target == `VIU_LAST_TARGET) ? 4'hF : 4'(call_target - 5'h01);

    sequence s_entry;
        inject_call;
    endsequence

    sequence s_return;
        instr_done && instr_is_reti && state == VIU_SERVICE && ce;
    endsequence

    AST_ENABLED_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        s_entry |-> |($past(en_pend) & (16'h0001 << tgt_idx)))
        else $error("vectored to a disabled or idle source");

    AST_FIXED_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        s_entry |-> ($past(en_pend) & ((16'h0001 << tgt_idx) - 16'h0001)) == 16'h0000)
        else $error("a more urgent request was passed over");

    AST_AT_INSTR_END: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(inject_call) |-> $past(instr_done))
        else $error("call injected in mid instruction");

    AST_TARGET_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        s_entry |-> call_target >= 5'h01 && call_target <= `VIU_LAST_TARGET)
        else $error("call target out of range");

    AST_NO_HOLE: assert property (@(posedge pclk) disable iff (!presetn)
        s_entry |-> call_target != `VIU_HOLE_TARGET)
        else $error("call to unassigned vector");

    AST_NO_NEST: assert property (@(posedge pclk) disable iff (!presetn)
        s_entry |-> in_service ##1 (!inject_call && in_service))
        else $error("nesting guard not held after entry");

    AST_GAP_AFTER_RETURN: assert property (@(posedge pclk) disable iff (!presetn)
        s_return |=> !inject_call ##1 !inject_call)
        else $error("entry without a main instruction after return");

    AST_EVENT_SETS: assert property (@(posedge pclk) disable iff (!presetn || !ce)
        ce && |src_event |=> (flag & $past(src_event)) == $past(src_event))
        else $error("event did not set its flag");

    AST_LEVEL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_go && (idx == `VIU_IDX_FLAG_LOW || idx == `VIU_IDX_FLAG_HIGH))
        |=> (flag & $past(flag)) == $past(flag))
        else $error("flag dropped without a clearing write");

    AST_CTX_SAVE: assert property (@(posedge pclk) disable iff (!presetn)
        accept && auto_save |=> acc_restore == $past(acc_in) && status_restore == $past(status_in))
        else $error("context not saved on entry");

    AST_RESTORE_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        s_return |=> restore_ctx == $past(auto_save))
        else $error("restore pulse does not follow the setup bit");

    AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
        ce && |en_pend |=> wake_req)
        else $error("pending enabled flag gave no wake request");

endmodule : viu_core
`default_nettype wire

/* File: sim/viu_cpu_model.sv */
// stand-in for the cpu sequencer: retires one instruction every gap+1 cycles
// assumes pclk/presetn of the interrupt unit; the bench raises reti_req
`timescale 1ns/1ps
`default_nettype none

module viu_cpu_model (
    input  wire logic       pclk,           // system clock
    input  wire logic       presetn,        // async reset, active low
    input  wire logic [3:0] gap,            // idle cycles between completions, keep at 1 or more
    input  wire logic       reti_req,       // next completion is a return
    output logic            instr_done,     // completion pulse
    output logic            instr_is_reti,  // qualifies instr_done
    output logic      [7:0] acc_in,         // live accumulator
    output logic      [7:0] status_in       // live status
);
    logic [3:0] idle_cnt;  // cycles since the last completion

    // context moves on every completion, so a save taken at the wrong edge shows up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt      <= 4'h0;
            instr_done    <= 1'b0;
            instr_is_reti <= 1'b0;
            acc_in        <= 8'h00;
            status_in     <= 8'h00;
        end else if (idle_cnt >= gap) begin
            idle_cnt      <= 4'h0;
            instr_done    <= 1'b1;
            instr_is_reti <= reti_req;
            acc_in        <= acc_in + 8'h35;
            status_in     <= status_in ^ 8'ha5;
        end else begin
            idle_cnt      <= idle_cnt + 4'h1;
            instr_done    <= 1'b0;
            instr_is_reti <= 1'b0;
        end
    end
endmodule : viu_cpu_model
`default_nettype wire

/* File: sim/viu_tb.sv */
// self-checking bench of the vectored interrupt unit, apb master plus cpu stand-in
// assumes viu_core, viu_cpu_model and viu_regs.svh; ce is kept high throughout
`timescale 1ns/1ps
`default_nettype none
`include "viu_regs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end

module tb;
    localparam logic [11:0] A_SET = {`VIU_IDX_SETUP, 2'b00};      // byte addresses
    localparam logic [11:0] A_FLO = {`VIU_IDX_FLAG_LOW, 2'b00};
    localparam logic [11:0] A_FHI = {`VIU_IDX_FLAG_HIGH, 2'b00};
    localparam logic [11:0] A_ENL = {`VIU_IDX_EN_LOW, 2'b00};
    localparam logic [11:0] A_ENH = {`VIU_IDX_EN_HIGH, 2'b00};
    localparam logic [11:0] A_IST = {`VIU_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_IMK = {`VIU_IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_CST = {`VIU_IDX_CORE_STATE, 2'b00};
    localparam int          HB[16] = '{0, 0, 0, 0, 0, 0, 0, 0, 4, 3, 5, 0, 1, 2, 6, 7};  // high flag bits

    logic        pclk = 1'b0;            // 40 mhz
    logic        presetn = 1'b0;         // held low from time zero
    logic        ce = 1'b1;              // freeze path not exercised, too costly in length
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [15:0] src_event = 16'h0000;   // event levels
    logic [3:0]  gap = 4'h1;             // cpu pace
    logic        reti_req = 1'b0, exp_auto = 1'b0, p_done = 1'b0;
    logic        pready, pslverr, instr_done, instr_is_reti, inject_call, restore_ctx, wake_req, irq;
    logic [4:0]  call_target, clk_setup;
    logic [7:0]  acc_in, status_in, acc_restore, status_restore, p_acc, p_sts, sav_a, sav_s;
    int          err_total = 0, compares = 0, n_rst = 0;

    viu_core i_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .src_event, .instr_done, .instr_is_reti, .acc_in, .status_in,
        .inject_call, .call_target, .restore_ctx, .acc_restore, .status_restore, .wake_req,
        .clk_setup, .irq);
    viu_cpu_model i_cpu (.pclk, .presetn, .gap, .reti_req, .instr_done, .instr_is_reti,
        .acc_in, .status_in);

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    // watches entries and restores; context is remembered from the accepting edge
    always @(posedge pclk) begin
        if (presetn === 1'b1 && inject_call === 1'b1) begin
            `CHK("done before call", 1'b1, p_done)
            sav_a = p_acc;
            sav_s = p_sts;
        end
        if (restore_ctx === 1'b1) begin
            n_rst++;
            `CHK("auto on", 1'b1, exp_auto)
            `CHK("acc back", sav_a, acc_restore)
            `CHK("status back", sav_s, status_restore)
        end
        p_done = instr_done;
        p_acc  = acc_in;
        p_sts  = status_in;
    end

    task automatic stop_test;
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // one apb transfer; request held until pready is seen, one idle cycle after
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        `CHK("pready", 1'b1, pready)
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        `CHK($sformatf("write err %h", a), 1'b0, e)
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        `CHK($sformatf("read %h", a), ex, r)
        `CHK($sformatf("read err %h", a), ee, e)
    endtask : rd

    // events are levels, so a one-cycle pulse sets the flag once
    task automatic pulse(input logic [15:0] v);
        src_event <= v;
        @(posedge pclk);
        src_event <= 16'h0000;
        @(posedge pclk);
    endtask : pulse

    // k completions pass with no entry
    task automatic quiet(input int k);
        int n;
        int seen;
        n = 0;
        seen = 0;
        while (seen < k && n < 300) begin
            @(posedge pclk);
            n++;
            `CHK("no call", 1'b0, inject_call)
            if (instr_done === 1'b1) seen++;
        end
    endtask : quiet

    // one handler: entry, firmware flag clear, return, then the guarded instruction
    task automatic serve(input logic [4:0] exp_t, input int src, input logic clr);
        logic [11:0] fa;
        logic [31:0] keep;
        int          n;
        fa   = (src < 8) ? A_FLO : A_FHI;
        keep = 32'h0000_00ff & ~(32'h1 << ((src < 8) ? 7 - src : HB[src]));
        n    = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (inject_call !== 1'b1 && n < 300);
        `CHK("call", 1'b1, inject_call)
        `CHK("call target", exp_t, call_target)
        `CHK("wake", 1'b1, wake_req)
        quiet(2);
        if (clr) wr(fa, keep);
        if (clr && src == 0) rd(A_FLO, 32'h0000_007f, 1'b0);
        reti_req <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!(instr_done === 1'b1 && instr_is_reti === 1'b1) && n < 600);
        reti_req <= 1'b0;
        do begin
            @(posedge pclk);
            n++;
            `CHK("guard", 1'b0, inject_call)
        end while (instr_done !== 1'b1 && n < 900);
    endtask : serve

    task automatic t_reset;
        rd(A_SET, 32'h0000_0000, 1'b0);
        rd(A_FLO, 32'h0000_0000, 1'b0);
        rd(A_FHI, 32'h0000_0000, 1'b0);
        rd(A_ENL, 32'h0000_0000, 1'b0);
        rd(12'hffc, 32'h0000_0000, 1'b1);
    endtask : t_reset

    // disabled source flags but never enters; enabled it re-enters while flag stays
    task automatic t_disabled;
        pulse(16'h0020);
        quiet(3);
        rd(A_FLO, 32'h0000_0004, 1'b0);
        `CHK("wake off", 1'b0, wake_req)
        wr(A_ENL, 32'h0000_0020);
        serve(5'h06, 5, 1'b0);
        serve(5'h06, 5, 1'b1);
    endtask : t_disabled

    task automatic t_irq;
        rd(A_IST, 32'h0000_0007, 1'b0);
        `CHK("irq masked", 1'b0, irq)
        wr(A_IMK, 32'h0000_0004);
        @(posedge pclk);
        `CHK("irq on", 1'b1, irq)
        wr(A_IST, 32'h0000_0004);
        @(posedge pclk);
        `CHK("irq off", 1'b0, irq)
        rd(A_IST, 32'h0000_0003, 1'b0);
    endtask : t_irq

    // all sixteen pending together, served strictly in the fixed order
    task automatic t_order;
        wr(A_ENL, 32'h0000_00ff);
        wr(A_ENH, 32'h0000_00ff);
        pulse(16'hffff);
        for (int i = 0; i < 16; i++) begin
            serve((i < 15) ? 5'(i + 1) : 5'h11, i, 1'b1);
        end
        rd(A_FLO, 32'h0000_0000, 1'b0);
        rd(A_FHI, 32'h0000_0000, 1'b0);
    endtask : t_order

    // slow cpu, automatic save on, lowest source
    task automatic t_auto;
        wr(A_SET, 32'h0000_003f);
        `CHK("clk setup", 5'h1f, clk_setup)
        exp_auto = 1'b1;
        gap <= 4'h5;
        pulse(16'h8000);
        serve(5'h11, 15, 1'b1);
        `CHK("restores", 1, n_rst)
        rd(A_CST, {16'h0000, sav_a, 8'h91}, 1'b0);
    endtask : t_auto

    initial begin
        #500_000;
        err_total++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_disabled();
        t_irq();
        t_order();
        t_auto();
        stop_test();
    end
endmodule : tb
`default_nettype wire
